/* hdl/rqt_consts.svh */
// Purpose: constants for the reading query and trigger model block
// Assumes: AXI4-Lite slave with 32-bit data
// Notes:   offsets are byte addresses
`ifndef RQT_CONSTS_SVH
`define RQT_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RQT_OFF_CTRL    8'h00
`define RQT_OFF_CMD     8'h04
`define RQT_OFF_STATUS  8'h08
`define RQT_OFF_RESULT  8'h0C
`define RQT_OFF_RAW     8'h10
`define RQT_OFF_MATH    8'h14
`define RQT_OFF_ERROR   8'h18
`define RQT_OFF_COUNT   8'h1C

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define RQT_CTRL_REARM    0
`define RQT_CTRL_ORG_LO   1
`define RQT_CTRL_SAMP_LO  4

// ----------------------------------------------------------------
// reset values and error codes (8-bit magnitude of negative codes)
// ----------------------------------------------------------------
`define RQT_RST_ORIGIN    2'h0
`define RQT_RST_SAMPLES   8'h01
`define RQT_RST_TRIGCNT   8'h01
`define RQT_ERR_NONE      8'h00
`define RQT_ERR_INIT_IGN  8'hD5
`define RQT_ERR_DEADLOCK  8'hD6
`define RQT_ERR_NO_MEM    8'hE1
`define RQT_ERR_STALE     8'hE6

`endif

/* hdl/rqt_pkg.sv */
// Purpose: types for the reading query and trigger model block
// Assumes: nothing
// Notes:   one-hot codes written out
package rqt_pkg;

  typedef enum logic [3:0] {
    CMD_NONE   = 4'h0,
    CMD_LATEST = 4'h1,
    CMD_TRIG   = 4'h2,
    CMD_ONCE   = 4'h3,
    CMD_UNSEEN = 4'h4,
    CMD_STALE  = 4'h5,
    CMD_ARM    = 4'h6,
    CMD_RESET  = 4'h7,
    CMD_RANGE  = 4'h8,
    CMD_MUNSEEN = 4'h9,
    CMD_MSTALE = 4'hA
  } rqt_cmd_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_ARM  = 4'b0100,
    ST_DONE = 4'b1000
  } rqt_state_e;

endpackage

/* hdl/rqt_bus_if.sv */
// Purpose: register-file carrier between the top and the slave
// Assumes: single clock
// Notes:   write strobe pulses one cycle
`timescale 1ns/1ps
interface rqt_bus_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [7:0]  rd_addr;
  logic        rd_en;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_ok;

  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, rd_en,
                 input rd_data, rd_ok, wr_ok);
  modport core  (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, rd_en,
                 output rd_data, rd_ok, wr_ok);
endinterface // rqt_bus_if

/* hdl/rqt_axil.sv */
// Purpose: AXI4-Lite slave front end
// Assumes: one write and one read under way at a time
// Notes:   answer two cycles after address and data are both taken
`timescale 1ns/1ps
module rqt_axil
  import rqt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  rqt_bus_if.slave         bus
);
  logic       aw_have_reg;
  logic       w_have_reg;
  logic [7:0] aw_reg;
  logic       rd_pend_reg;
  wire        aw_take = awvalid_i && awready_o;
  wire        w_take  = wvalid_i && wready_o;
  wire        both    = (aw_have_reg || aw_take) && (w_have_reg || w_take) && !bvalid_o && !bus.wr_en;

  // ----------------------------------------------------------------
  // write channels, taken in either order
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      awready_o   <= 1'b1;
      wready_o    <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_reg      <= 8'h00;
      bus.wr_en   <= 1'b0;
      bus.wr_addr <= 8'h00;
      bus.wr_data <= 32'h0000_0000;
      bus.wr_strb <= 4'h0;
      bvalid_o    <= 1'b0;
      bresp_o     <= 2'h0;
    end else begin
      bus.wr_en <= 1'b0;
      if (aw_take) begin
        aw_reg      <= awaddr_i;
        aw_have_reg <= 1'b1;
        awready_o   <= 1'b0;
      end
      if (w_take) begin
        bus.wr_data <= wdata_i;
        bus.wr_strb <= wstrb_i;
        w_have_reg  <= 1'b1;
        wready_o    <= 1'b0;
      end
      if (both) begin
        bus.wr_en   <= 1'b1;
        bus.wr_addr <= aw_take ? awaddr_i : aw_reg;
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
      end
      if (bus.wr_en) begin
        bvalid_o <= 1'b1;
        bresp_o  <= bus.wr_ok ? 2'h0 : 2'h2;
      end
      if (bvalid_o && bready_i) begin
        bvalid_o  <= 1'b0;
        awready_o <= 1'b1;
        wready_o  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arready_o   <= 1'b1;
      bus.rd_en   <= 1'b0;
      bus.rd_addr <= 8'h00;
      rd_pend_reg <= 1'b0;
      rvalid_o    <= 1'b0;
      rdata_o     <= 32'h0000_0000;
      rresp_o     <= 2'h0;
    end else begin
      bus.rd_en <= 1'b0;
      if (arvalid_i && arready_o) begin
        bus.rd_addr <= araddr_i;
        bus.rd_en   <= 1'b1;
        arready_o   <= 1'b0;
        rd_pend_reg <= 1'b1;
      end
      if (rd_pend_reg && !bus.rd_en) begin
        rd_pend_reg <= 1'b0;
        rvalid_o    <= 1'b1;
        rdata_o     <= bus.rd_data;
        rresp_o     <= bus.rd_ok ? 2'h0 : 2'h2;
      end
      if (rvalid_o && rready_i) begin
        rvalid_o  <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end
endmodule // rqt_axil

/* hdl/rqt_top.sv */
// Purpose: reading query and trigger model sequencer
// Assumes: 20 MHz clock, synchronous reset, AXI4-Lite access
// Notes:   front end delivers readings on a done pulse
// What this block does
// - latest query returns held reading, starts nothing, never waits
// - latest query with no valid reading posts stale error
// - held reading stays valid until new trigger or range/function change
// - multi-sample trigger readings go into the buffer
// - trigger query aborts to idle, arms, waits for new reading
// - trigger query delivers a newly taken reading unless it posts a deadlock or no-memory error
// - trigger query returns as many readings as the sample count
// - trigger query with bus or external origin posts deadlock error
// - with re-arming on, trigger query posts init-ignored yet returns fresh
// - general reset: re-arm off, origin immediate, repeat count one
// - one-shot query: function, immediate, count one, defaults, trigger, return
// - unseen query never triggers and never repeats a reading
// - unseen query waits for a reading in progress
// - stale-tolerant query returns last reading even when invalidated
// - math variants behave alike on math-scaled readings
// - stored buffer data locks out arm and multi-sample trigger query
// - reading-available bit set on completion; host checks it first
// - arm while running is ignored and posts init-ignored error
// - repeated unseen query posts stale error
`timescale 1ns/1ps
module rqt_top
  import rqt_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  input  wire logic        READING_DONE_I,
  input  wire logic [31:0] READING_RAW_I,
  input  wire logic [31:0] READING_MATH_I,
  input  wire logic        EXT_TRIG_I,
  input  wire logic        BUF_STORED_I,
  output logic             MEAS_START_O,
  output logic             MEAS_ABORT_O,
  output logic             LOAD_DEFAULTS_O,
  output logic [3:0]       FUNC_SEL_O,
  output logic             BUF_WRITE_O,
  output logic             BUSY_O
);
`include "rqt_consts.svh"

  rqt_bus_if bus ();

  rqt_axil u_axil (
    .clk_i     (SYS_CLK_I),
    .rst_i     (RST_I),
    .awaddr_i  (AWADDR_I),
    .awvalid_i (AWVALID_I),
    .awready_o (AWREADY_O),
    .wdata_i   (WDATA_I),
    .wstrb_i   (WSTRB_I),
    .wvalid_i  (WVALID_I),
    .wready_o  (WREADY_O),
    .bresp_o   (BRESP_O),
    .bvalid_o  (BVALID_O),
    .bready_i  (BREADY_I),
    .araddr_i  (ARADDR_I),
    .arvalid_i (ARVALID_I),
    .arready_o (ARREADY_O),
    .rdata_o   (RDATA_O),
    .rresp_o   (RRESP_O),
    .rvalid_o  (RVALID_O),
    .rready_i  (RREADY_I),
    .bus       (bus)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic        auto_rearm_reg;
  logic [1:0]  trigger_origin_reg;
  logic [7:0]  samples_reg;
  logic [7:0]  trigger_repeat_count_reg;
  logic [31:0] raw_reg;
  logic [31:0] math_reg;
  logic [31:0] result_reg;
  logic        valid_reg;
  logic        fresh_reg;
  logic        reading_available_bit_reg;
  logic        result_ready_reg;
  logic [7:0]  error_reg;
  logic [7:0]  remain_reg;
  logic        pend_math_reg;
  logic        pend_unseen_reg;
  rqt_state_e  state_reg;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  wire        wr_cmd   = bus.wr_en && hit(bus.wr_addr, `RQT_OFF_CMD) && bus.wr_strb[0];
  wire        wr_ctrl  = bus.wr_en && hit(bus.wr_addr, `RQT_OFF_CTRL);
  wire [3:0]  cmd_code = bus.wr_data[3:0];
  wire [3:0]  cmd_func = bus.wr_data[7:4];
  wire        running  = (state_reg != ST_IDLE) || auto_rearm_reg;
  wire        ext_org  = trigger_origin_reg != `RQT_RST_ORIGIN;
  wire        locked   = BUF_STORED_I;
  wire        multi    = samples_reg > 8'h01;
  wire        is_cmd   = wr_cmd && (cmd_code inside {CMD_LATEST, CMD_TRIG, CMD_ONCE, CMD_UNSEEN, CMD_STALE,
                                                    CMD_ARM, CMD_RESET, CMD_RANGE, CMD_MUNSEEN, CMD_MSTALE});
  wire        got      = READING_DONE_I;
  wire        rd_reg   = bus.rd_en && hit(bus.rd_addr, `RQT_OFF_RESULT);
  wire        wr_known = hit(bus.wr_addr, `RQT_OFF_CTRL) || hit(bus.wr_addr, `RQT_OFF_CMD);

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (bus.rd_addr)
      `RQT_OFF_CTRL:   rd_mux = {12'h000, samples_reg, 5'h00, trigger_origin_reg, auto_rearm_reg,
                                 trigger_repeat_count_reg[3:0]};
      `RQT_OFF_STATUS: rd_mux = {24'h0000_00, state_reg, result_ready_reg, reading_available_bit_reg,
                                 fresh_reg, valid_reg};
      `RQT_OFF_RESULT: rd_mux = result_reg;
      `RQT_OFF_RAW:    rd_mux = raw_reg;
      `RQT_OFF_MATH:   rd_mux = math_reg;
      `RQT_OFF_ERROR:  rd_mux = {24'h0000_00, error_reg};
      `RQT_OFF_COUNT:  rd_mux = {16'h0000, trigger_repeat_count_reg, remain_reg};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign bus.rd_data = rd_mux;
  assign bus.rd_ok   = rd_hit;
  assign bus.wr_ok   = wr_known;

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || (is_cmd && cmd_code == CMD_RESET)) begin
      auto_rearm_reg           <= 1'b0;
      trigger_origin_reg       <= `RQT_RST_ORIGIN;
      trigger_repeat_count_reg <= `RQT_RST_TRIGCNT;
      samples_reg              <= `RQT_RST_SAMPLES;
    end else if (is_cmd && cmd_code == CMD_ONCE) begin
      trigger_origin_reg       <= `RQT_RST_ORIGIN;
      trigger_repeat_count_reg <= `RQT_RST_TRIGCNT;
      samples_reg              <= `RQT_RST_SAMPLES;
    end else if (wr_ctrl) begin
      auto_rearm_reg     <= bus.wr_data[`RQT_CTRL_REARM];
      trigger_origin_reg <= bus.wr_data[`RQT_CTRL_ORG_LO +: 2];
      samples_reg        <= bus.wr_data[`RQT_CTRL_SAMP_LO +: 8];
    end
  end

  // ----------------------------------------------------------------
  // held reading and flags
  // ----------------------------------------------------------------
  wire abort_now = is_cmd && (cmd_code == CMD_TRIG || cmd_code == CMD_ONCE) && !(cmd_code == CMD_TRIG &&
                   (ext_org || (locked && multi)));
  wire inval     = abort_now || (is_cmd && cmd_code == CMD_RANGE);
  wire take_un   = is_cmd && (cmd_code == CMD_UNSEEN || cmd_code == CMD_MUNSEEN) && fresh_reg;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      raw_reg   <= 32'h0000_0000;
      math_reg  <= 32'h0000_0000;
      valid_reg <= 1'b0;
      fresh_reg <= 1'b0;
      reading_available_bit_reg <= 1'b0;
    end else begin
      if (inval) begin
        valid_reg <= 1'b0;
        fresh_reg <= 1'b0;
        reading_available_bit_reg <= 1'b0;
      end else if (take_un) begin
        fresh_reg <= 1'b0;
      end
      if (got) begin
        raw_reg   <= READING_RAW_I;
        math_reg  <= READING_MATH_I;
        valid_reg <= 1'b1;
        fresh_reg <= !pend_unseen_reg;                  // set wins, unless a waiting query takes it
        reading_available_bit_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // trigger model and query sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state_reg        <= ST_IDLE;
      result_reg       <= 32'h0000_0000;
      result_ready_reg <= 1'b0;
      error_reg        <= `RQT_ERR_NONE;
      remain_reg       <= 8'h00;
      pend_math_reg    <= 1'b0;
      pend_unseen_reg  <= 1'b0;
      MEAS_START_O     <= 1'b0;
      MEAS_ABORT_O     <= 1'b0;
      LOAD_DEFAULTS_O  <= 1'b0;
      FUNC_SEL_O       <= 4'h0;
      BUF_WRITE_O      <= 1'b0;
      BUSY_O           <= 1'b0;
    end else begin
      MEAS_START_O    <= 1'b0;
      MEAS_ABORT_O    <= 1'b0;
      LOAD_DEFAULTS_O <= 1'b0;
      BUF_WRITE_O     <= 1'b0;
      if (rd_reg) begin
        result_ready_reg <= 1'b0;
      end
      // a pending unseen query completes on the next reading
      if (pend_unseen_reg && got) begin
        result_reg       <= pend_math_reg ? READING_MATH_I : READING_RAW_I;
        result_ready_reg <= 1'b1;
        pend_unseen_reg  <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (is_cmd) begin
            case (cmd_code)
              CMD_LATEST: begin
                if (valid_reg) begin
                  result_reg       <= raw_reg;
                  result_ready_reg <= 1'b1;
                end else begin
                  error_reg <= `RQT_ERR_STALE;
                end
              end
              CMD_STALE, CMD_MSTALE: begin
                result_reg       <= (cmd_code == CMD_MSTALE) ? math_reg : raw_reg;
                result_ready_reg <= 1'b1;
              end
              CMD_UNSEEN, CMD_MUNSEEN: begin
                if (fresh_reg) begin
                  result_reg       <= (cmd_code == CMD_MUNSEEN) ? math_reg : raw_reg;
                  result_ready_reg <= 1'b1;
                end else if (BUSY_O) begin
                  pend_unseen_reg <= 1'b1;
                  pend_math_reg   <= cmd_code == CMD_MUNSEEN;
                end else begin
                  error_reg <= `RQT_ERR_STALE;
                end
              end
              CMD_ARM: begin
                if (locked) begin
                  error_reg <= `RQT_ERR_NO_MEM;
                end else if (running) begin
                  error_reg <= `RQT_ERR_INIT_IGN;
                end else begin
                  state_reg  <= ST_ARM;
                  remain_reg <= samples_reg;
                end
              end
              CMD_TRIG, CMD_ONCE: begin
                if (cmd_code == CMD_TRIG && ext_org) begin
                  error_reg <= `RQT_ERR_DEADLOCK;
                end else if (cmd_code == CMD_TRIG && locked && multi) begin
                  error_reg <= `RQT_ERR_NO_MEM;
                end else begin
                  if (cmd_code == CMD_TRIG && auto_rearm_reg) begin
                    error_reg <= `RQT_ERR_INIT_IGN;
                  end
                  if (cmd_code == CMD_ONCE) begin
                    FUNC_SEL_O      <= cmd_func;
                    LOAD_DEFAULTS_O <= 1'b1;
                  end
                  MEAS_ABORT_O <= 1'b1;
                  remain_reg   <= (cmd_code == CMD_ONCE) ? 8'h01 : samples_reg;
                  state_reg    <= ST_WAIT;
                end
              end
              default: begin
              end
            endcase
          end
        end
        ST_ARM: begin
          MEAS_START_O <= 1'b1;
          BUSY_O       <= 1'b1;
          state_reg    <= ST_DONE;
        end
        ST_WAIT: begin
          MEAS_START_O <= 1'b1;                         // arm out of idle after abort
          BUSY_O       <= 1'b1;
          state_reg    <= ST_DONE;
          result_ready_reg <= 1'b0;
        end
        ST_DONE: begin
          if (is_cmd && (cmd_code == CMD_UNSEEN || cmd_code == CMD_MUNSEEN)) begin
            pend_unseen_reg <= 1'b1;
            pend_math_reg   <= cmd_code == CMD_MUNSEEN;
          end
          if (is_cmd && cmd_code == CMD_ARM) begin
            error_reg <= `RQT_ERR_INIT_IGN;
          end
          if (got) begin
            result_reg       <= (pend_unseen_reg && pend_math_reg) ? READING_MATH_I : READING_RAW_I;
            result_ready_reg <= 1'b1;
            BUF_WRITE_O      <= multi;
            if (remain_reg <= 8'h01) begin
              remain_reg <= 8'h00;
              BUSY_O     <= 1'b0;
              state_reg  <= ST_IDLE;
            end else begin
              remain_reg   <= remain_reg - 8'h01;
              MEAS_START_O <= 1'b1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // rqt_top

/* tb/rqt_props.sv */
// Purpose: port checker for rqt_top
// Assumes: one clock, sync reset
// Notes:   bound to rqt_top below
`timescale 1ns/1ps
module rqt_props (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic MEAS_START_O,
  input wire logic MEAS_ABORT_O,
  input wire logic BUSY_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // ------------------------------------------------
  // bus and sequencer relations
  // ------------------------------------------------
  b_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O) else $error("bvalid dropped");
  r_hold_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O) else $error("rvalid dropped");
  b_latency_a: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O)
    else $error("write answer late");
  r_latency_a: assert property (ARVALID_I && ARREADY_O |-> ##3 RVALID_O) else $error("read answer late");
  aw_blocked_a: assert property (BVALID_O |-> !AWREADY_O) else $error("awready during response");
  abort_start_a: assert property (MEAS_ABORT_O |=> MEAS_START_O) else $error("no start after abort");
  abort_pulse_a: assert property (MEAS_ABORT_O |=> !MEAS_ABORT_O) else $error("abort not a pulse");
  start_busy_a: assert property (MEAS_START_O |=> BUSY_O) else $error("start without busy");
  c_write_c: cover property (BVALID_O && BREADY_I);
  c_abort_c: cover property (MEAS_ABORT_O);
  c_busy_c: cover property ($fell(BUSY_O));
endmodule // rqt_props

bind rqt_top rqt_props i_props (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .AWVALID_I(AWVALID_I),
  .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BVALID_O(BVALID_O),
  .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O),
  .RREADY_I(RREADY_I), .MEAS_START_O(MEAS_START_O), .MEAS_ABORT_O(MEAS_ABORT_O), .BUSY_O(BUSY_O));

/* tb/rqt_front.sv */
// Purpose: measurement front end model
// Assumes: one reading per start, more while busy
// Notes:   data lines toggle outside the done pulse
`timescale 1ns/1ps
module rqt_front (
  input  wire logic        clk_i,
  input  wire logic        start_i,
  input  wire logic        busy_i,
  input  wire logic        slow_i,
  input  wire logic [31:0] val_i,
  output logic             done_o = 1'b0,
  output logic [31:0]      raw_o = 32'h0,
  output logic [31:0]      math_o = 32'h0
);
  int          cnt = -1;
  logic [31:0] v = 32'h0;
  // countdown to each reading, math is raw plus seven
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (start_i) begin
      cnt <= slow_i ? 12 : 3;
      v <= val_i;
    end else if (cnt > 0) cnt <= cnt - 1;
    else if (cnt == 0 && busy_i) begin
      done_o <= 1'b1;
      raw_o <= v;
      math_o <= v + 32'h7;
      cnt <= 3;
    end else begin
      cnt <= -1;
      raw_o <= ~raw_o;
      math_o <= ~math_o;
    end
  end
endmodule // rqt_front

/* tb/tb.sv */
// Purpose: self-checking bench for rqt_top
// Assumes: 20 MHz clock, AXI4-Lite master tasks
// Notes:   expected readings kept in a model variable
`timescale 1ns/1ps
`include "rqt_consts.svh"
module tb;
  import rqt_pkg::*;
  logic SYS_CLK_I = 0, RST_I = 1, AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0, ARVALID_I = 0, RREADY_I = 0;
  logic [7:0] AWADDR_I = 0, ARADDR_I = 0;
  logic [31:0] WDATA_I = 0, READING_RAW_I, READING_MATH_I, d, val = 32'h16C7, last = 0;
  logic [3:0] WSTRB_I = 4'hF, FUNC_SEL_O;
  logic READING_DONE_I, EXT_TRIG_I = 0, BUF_STORED_I = 0, slow = 0;
  wire AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, MEAS_START_O, MEAS_ABORT_O;
  wire LOAD_DEFAULTS_O, BUF_WRITE_O, BUSY_O;
  wire [1:0] BRESP_O, RRESP_O;
  wire [31:0] RDATA_O;
  int miscompares = 0, samples_checked = 0, bw = 0, ld = 0;
  rqt_top i_dut (.*);
  rqt_front i_front (.clk_i(SYS_CLK_I), .start_i(MEAS_START_O), .busy_i(BUSY_O), .slow_i(slow),
    .val_i(val), .done_o(READING_DONE_I), .raw_o(READING_RAW_I), .math_o(READING_MATH_I));
  // clock and buffer write counter
  always #25 SYS_CLK_I = ~SYS_CLK_I;
  always @(posedge SYS_CLK_I) begin
    if (BUF_WRITE_O === 1'b1) bw++;
    if (LOAD_DEFAULTS_O === 1'b1) ld++;
  end
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic finish_test(input bit hang);
    if (hang) miscompares++;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    bit b;
    b = 0;
    AWADDR_I <= a; WDATA_I <= v; AWVALID_I <= 1; WVALID_I <= 1; BREADY_I <= 1;
    for (n = 0; n < 300 && !b; n++) begin
      @(posedge SYS_CLK_I);
      if (AWREADY_O) AWVALID_I <= 0;
      if (WREADY_O) WVALID_I <= 0;
      if (BVALID_O) begin b = 1; BREADY_I <= 0; end
    end
    if (!b) finish_test(1);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    bit b;
    b = 0;
    ARADDR_I <= a; ARVALID_I <= 1; RREADY_I <= 1;
    for (n = 0; n < 300 && !b; n++) begin
      @(posedge SYS_CLK_I);
      if (ARREADY_O) ARVALID_I <= 0;
      if (RVALID_O) begin b = 1; d = RDATA_O; RREADY_I <= 0; end
    end
    if (!b) finish_test(1);
  endtask
  task automatic cmd(input logic [7:0] c);
    int n;
    wr(`RQT_OFF_CMD, {24'h0, c});
    repeat (3) @(posedge SYS_CLK_I);
    for (n = 0; n < 400 && BUSY_O !== 1'b0; n++) @(posedge SYS_CLK_I);
    if (n == 400) finish_test(1);
  endtask
  task automatic trig();
    val = xs(val);
    last = val;
    cmd(8'h02);
  endtask
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    repeat (8) @(posedge SYS_CLK_I);
    RST_I <= 0;
    @(posedge SYS_CLK_I);
    cmd(8'h01); rd(`RQT_OFF_ERROR); chk(d[7:0], `RQT_ERR_STALE);
    wr(`RQT_OFF_CTRL, 32'h12); cmd(8'h02); rd(`RQT_OFF_ERROR); chk(d[7:0], `RQT_ERR_DEADLOCK);
    wr(`RQT_OFF_CTRL, 32'h10);
    $display("test errors done");
    trig(); rd(`RQT_OFF_RESULT); chk(d, last);
    rd(`RQT_OFF_STATUS); chk(d[0], 1'b1);
    repeat (2) begin
      cmd(8'h01); rd(`RQT_OFF_RESULT); chk(d, last);
    end
    cmd(8'h04); rd(`RQT_OFF_RESULT); chk(d, last);
    cmd(8'h04); rd(`RQT_OFF_ERROR); chk(d[7:0], `RQT_ERR_STALE);
    trig(); cmd(8'h09); rd(`RQT_OFF_RESULT); chk(d, last + 32'h7);
    cmd(8'h08); rd(`RQT_OFF_STATUS); chk(d[0], 1'b0);
    cmd(8'h05); rd(`RQT_OFF_RESULT); chk(d, last);
    $display("test queries done");
    wr(`RQT_OFF_CTRL, 32'h20); bw = 0; trig(); @(posedge SYS_CLK_I); chk(bw, 2);
    BUF_STORED_I <= 1; cmd(8'h02); rd(`RQT_OFF_ERROR); chk(d[7:0], `RQT_ERR_NO_MEM);
    BUF_STORED_I <= 0; wr(`RQT_OFF_CTRL, 32'h11);
    trig(); rd(`RQT_OFF_ERROR); chk(d[7:0], `RQT_ERR_INIT_IGN);
    rd(`RQT_OFF_RESULT); chk(d, last);
    cmd(8'h04); cmd(8'h04); cmd(8'h06); rd(`RQT_OFF_ERROR); chk(d[7:0], `RQT_ERR_INIT_IGN);
    wr(`RQT_OFF_CTRL, 32'h10);
    slow <= 1; val = xs(val); last = val; wr(`RQT_OFF_CMD, 32'h06); cmd(8'h04);
    rd(`RQT_OFF_STATUS); chk(d[2], 1'b1);
    rd(`RQT_OFF_RESULT); chk(d, last);
    cmd(8'h01); rd(`RQT_OFF_RESULT); chk(d, last);
    val = xs(val); last = val; cmd(8'h53); chk(FUNC_SEL_O, 4'h5); chk(ld, 1);
    rd(`RQT_OFF_RESULT); chk(d, last);
    wr(`RQT_OFF_CTRL, 32'h15); cmd(8'h07); rd(`RQT_OFF_CTRL); chk(d[6:0], 7'h01);
    $display("test modes done");
    finish_test(0);
  end
endmodule // tb
